// ### shared/fpd_pkg.sv
// Purpose: constants and carrier types for the fast-page dynamic memory controller
// Assumes: 40 MHz mclk, 25 ns period
// Notes:   cycle counts derive from the printed times; least times round up
package fpd_pkg;
  localparam int CLK_PS              = 25000;
  localparam int ROW_ACTIVE_NS       = 50;
  localparam int ROW_PRECHARGE_NS    = 30;
  localparam int COL_PRECHARGE_NS    = 9;
  localparam int ROW_TO_COL_NS       = 12;
  localparam int COL_ACCESS_NS       = 25;
  localparam int ROW_ACCESS_NS       = 50;
  localparam int COL_PULSE_NS        = 20;
  localparam int CBR_SETUP_NS        = 5;
  localparam int POWER_UP_US         = 200;
  localparam int REFRESH_MS          = 16;
  localparam int REFRESH_ROWS        = 1024;
  localparam int WAKE_CYCLES         = 8;

  function automatic int ns_up(input int ns);
    int c;
    c = (ns * 1000 + CLK_PS - 1) / CLK_PS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int ROW_ACTIVE_CYC      = ns_up(ROW_ACTIVE_NS);
  localparam int ROW_PRECHARGE_CYC   = ns_up(ROW_PRECHARGE_NS);
  localparam int COL_PRECHARGE_CYC   = ns_up(COL_PRECHARGE_NS);
  localparam int ROW_TO_COL_CYC      = ns_up(ROW_TO_COL_NS);
  localparam int COL_PULSE_CYC       = ns_up(COL_PULSE_NS);
  localparam int CBR_SETUP_CYC       = ns_up(CBR_SETUP_NS);
  // read data are sampled once access is over: one edge of margin, two sync stages
  localparam int READ_WAIT_CYC       = ns_up(COL_ACCESS_NS) + 3;
  localparam int POWER_UP_CYC        = (POWER_UP_US * 1000000) / CLK_PS;
  // longest refresh interval per row rounds down
  localparam int REFRESH_INT_CYC     = (REFRESH_MS * (1000000000 / CLK_PS)) / REFRESH_ROWS;
  localparam int TIMER_W             = 16;
  localparam int ADDR_W              = 10;
  localparam int DATA_W              = 16;
  localparam logic [2:0] WAKE_LAST   = 3'h7;

  typedef struct packed {
    logic [19:0] addr;   // row in the upper ten bits, column in the lower ten
    logic [15:0] wdata;
    logic [1:0]  lanes;  // bit 0 lower byte, bit 1 upper byte
    logic        write;
  } fpd_req_type;

  typedef struct packed {
    logic        row_strobe_n;
    logic        lower_col_strobe_n;
    logic        upper_col_strobe_n;
    logic        write_en_n;
    logic        out_en_n;
  } fpd_strobe_type;
endpackage

// ### hw/fpd_timer.sv
// Purpose: down-counter that times strobe phases
// Assumes: load and count share the clock enable of the controller
// Notes:   done is high while the count stands at zero
`timescale 1ns/1ps
module fpd_timer (
  input  wire logic                      mclk,
  input  wire logic                      resetn,
  input  wire logic                      ce,
  input  wire logic                      load,
  input  wire logic [fpd_pkg::TIMER_W-1:0] value,
  output logic                           done
);
  logic [fpd_pkg::TIMER_W-1:0] count;

  // load wins over counting down
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      count <= '0;
    end else if (ce) begin
      if (load) begin
        count <= value;
      end else if (count != '0) begin
        count <= count - 1'b1;
      end
    end
  end

  assign done = (count == '0);
endmodule

// ### hw/fpd_ctrl.sv
// Purpose: controller driving an asynchronous fast-page dynamic memory by its strobes
// Assumes: one request port; refresh and wake-up are generated internally
// Notes:   holds a row open for page hits; refresh by column-before-row
`timescale 1ns/1ps
module fpd_ctrl #(
  parameter int POWER_UP_CYCLES = fpd_pkg::POWER_UP_CYC,
  parameter int REFRESH_CYCLES  = fpd_pkg::REFRESH_INT_CYC
) (
  input  wire logic                       mclk,
  input  wire logic                       resetn,
  input  wire logic                       ce,
  input  wire logic                       req_valid,
  input  wire fpd_pkg::fpd_req_type       req,
  output logic                            req_ready,
  output logic                            rsp_valid,
  output logic [fpd_pkg::DATA_W-1:0]      rsp_data,
  output logic                            init_done,
  output fpd_pkg::fpd_strobe_type         strobes,
  output logic [fpd_pkg::ADDR_W-1:0]      mux_address_bus,
  output logic [fpd_pkg::DATA_W-1:0]      data_pins_out,
  output logic [1:0]                      data_pins_oe,
  input  wire logic [fpd_pkg::DATA_W-1:0] data_pins_in
);
  typedef enum {
    ST_POWER, ST_IDLE, ST_ROW, ST_COL, ST_COL_PRE, ST_OPEN, ST_CLOSE,
    ST_PRE, ST_CBR_COL, ST_CBR_ROW
  } fpd_state_type;

  fpd_state_type               state;
  logic [fpd_pkg::DATA_W-1:0]  sync1;
  logic [fpd_pkg::DATA_W-1:0]  sync2;
  logic [fpd_pkg::ADDR_W-1:0]  open_row;
  logic                        row_open;
  logic [2:0]                  wake_count;
  logic                        waking;
  logic                        ref_due;
  logic                        ref_late;
  logic [fpd_pkg::TIMER_W-1:0] ref_count;
  logic [fpd_pkg::TIMER_W-1:0] ras_count;
  logic                        cur_write;
  logic [1:0]                  cur_lanes;
  logic [fpd_pkg::ADDR_W-1:0]  cur_col;
  logic                        t_load;
  logic [fpd_pkg::TIMER_W-1:0] t_value;
  logic                        t_done;

  function automatic logic [fpd_pkg::TIMER_W-1:0] cyc(input int n);
    return fpd_pkg::TIMER_W'(n - 1);
  endfunction

  // decode of the request against the open row
  wire [fpd_pkg::ADDR_W-1:0] req_row  = req.addr[19:10];
  wire [fpd_pkg::ADDR_W-1:0] req_col  = req.addr[9:0];
  wire                       page_hit = row_open && (req_row == open_row);
  wire                       ras_ok   = (ras_count >= fpd_pkg::TIMER_W'(fpd_pkg::ROW_ACTIVE_CYC));
  wire                       take     = req_valid && req_ready;
  wire                       row_set  = (mux_address_bus == req_row);

  fpd_timer u_timer (
    .mclk   (mclk),
    .resetn (resetn),
    .ce     (ce),
    .load   (t_load),
    .value  (t_value),
    .done   (t_done)
  );

  // data pins come from outside the clock domain: two flops before use
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sync1 <= '0;
      sync2 <= '0;
    end else if (ce) begin
      sync1 <= data_pins_in;
      sync2 <= sync1;
    end
  end

  // refresh interval timer and row-active time counter
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ref_count <= '0;
      ref_due   <= 1'b0;
      ref_late  <= 1'b0;
      ras_count <= '0;
    end else if (ce) begin
      ras_count <= strobes.row_strobe_n ? '0 : ras_count + 1'b1;
      if (state == ST_CBR_ROW && t_done) begin
        ref_count <= '0;
        ref_due   <= 1'b0;
        ref_late  <= 1'b0;
      end else if (state == ST_POWER) begin
        ref_count <= ref_count + 1'b1;
      end else if (init_done) begin
        ref_count <= ref_count + 1'b1;
        if (ref_count == fpd_pkg::TIMER_W'(REFRESH_CYCLES - 1)) begin
          ref_due <= 1'b1;
        end
        if (ref_count == fpd_pkg::TIMER_W'(2 * REFRESH_CYCLES - 1)) begin
          ref_late <= 1'b1;
        end
      end
    end
  end

  // timer load requests per state transition
  always_comb begin
    t_load  = 1'b0;
    t_value = '0;
    case (state)
      ST_POWER: begin
        t_load  = 1'b0;
      end
      ST_ROW: begin
        t_load  = t_done;
        t_value = cur_write ? cyc(fpd_pkg::COL_PULSE_CYC) : cyc(fpd_pkg::READ_WAIT_CYC);
      end
      ST_COL: begin
        t_load  = t_done;
        t_value = cyc(fpd_pkg::COL_PRECHARGE_CYC);
      end
      ST_OPEN: begin
        t_load  = take && page_hit;
        t_value = cyc(1);
      end
      ST_CLOSE: begin
        t_load  = ras_ok;
        t_value = cyc(fpd_pkg::ROW_PRECHARGE_CYC);
      end
      ST_IDLE: begin
        t_load  = 1'b1;
        t_value = (ref_due || waking) ? cyc(fpd_pkg::CBR_SETUP_CYC)
                                      : cyc(fpd_pkg::ROW_TO_COL_CYC + 1);
      end
      ST_CBR_COL: begin
        t_load  = t_done;
        t_value = cyc(fpd_pkg::ROW_ACTIVE_CYC);
      end
      ST_CBR_ROW: begin
        t_load  = t_done;
        t_value = cyc(fpd_pkg::ROW_PRECHARGE_CYC);
      end
      default: begin
        t_load  = 1'b0;
      end
    endcase
  end

  // main sequencer
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state           <= ST_POWER;
      strobes         <= '1;
      mux_address_bus <= '0;
      data_pins_out   <= '0;
      data_pins_oe    <= 2'h0;
      req_ready       <= 1'b0;
      rsp_valid       <= 1'b0;
      rsp_data        <= '0;
      init_done       <= 1'b0;
      open_row        <= '0;
      row_open        <= 1'b0;
      wake_count      <= 3'h0;
      waking          <= 1'b1;
      cur_write       <= 1'b0;
      cur_lanes       <= 2'h0;
      cur_col         <= '0;
    end else if (ce) begin
      rsp_valid <= 1'b0;
      req_ready <= 1'b0;
      case (state)
        ST_POWER: begin
          // power-up pause counted in the refresh counter
          if (ref_count >= fpd_pkg::TIMER_W'(POWER_UP_CYCLES)) begin
            state <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          strobes <= '1;
          if (ref_due || waking) begin
            strobes.lower_col_strobe_n <= 1'b0;
            strobes.upper_col_strobe_n <= 1'b0;
            data_pins_oe               <= 2'h0;
            state                      <= ST_CBR_COL;
          end else begin
            // row address settles one cycle before the row strobe falls
            mux_address_bus <= req_row;
            if (req_valid && row_set) begin
              strobes.row_strobe_n <= 1'b0;
              open_row             <= req_row;
              row_open             <= 1'b1;
              cur_write            <= req.write;
              cur_lanes            <= req.lanes;
              cur_col              <= req_col;
              req_ready            <= 1'b1;
              data_pins_out        <= req.wdata;
              state                <= ST_ROW;
            end
          end
        end
        ST_ROW: begin
          if (t_done) begin
            // early write: data precede the column strobes; write enable falls on the same edge as them
            strobes.write_en_n         <= ~cur_write;
            strobes.out_en_n           <= cur_write;
            strobes.lower_col_strobe_n <= ~cur_lanes[0];
            strobes.upper_col_strobe_n <= ~cur_lanes[1];
            state                      <= ST_COL;
          end else begin
            // column address and write data settle before the column strobes
            mux_address_bus <= cur_col;
            data_pins_oe    <= cur_write ? cur_lanes : 2'h0;
          end
        end
        ST_OPEN: begin
          if (take && page_hit) begin
            mux_address_bus <= req_col;
            cur_write       <= req.write;
            cur_lanes       <= req.lanes;
            data_pins_out   <= req.wdata;
            data_pins_oe    <= req.write ? req.lanes : 2'h0;
            state           <= ST_ROW;
          end else begin
            // ready only for a held request that hits the open row
            req_ready <= !ref_due && req_valid && page_hit;
            if (ref_due || (req_valid && !page_hit && !req_ready)) begin
              state <= ST_CLOSE;
            end
          end
        end
        ST_COL: begin
          if (t_done) begin
            // read data sampled after every access time has run out
            rsp_data  <= sync2;
            rsp_valid <= 1'b1;
            strobes.lower_col_strobe_n <= 1'b1;
            strobes.upper_col_strobe_n <= 1'b1;
            strobes.write_en_n         <= 1'b1;
            strobes.out_en_n           <= 1'b1;
            data_pins_oe               <= 2'h0;
            state                      <= ST_COL_PRE;
          end
        end
        ST_COL_PRE: begin
          if (t_done) begin
            state <= ST_OPEN;
          end
        end
        ST_CLOSE: begin
          if (ras_ok) begin
            strobes  <= '1;
            row_open <= 1'b0;
            state    <= ST_PRE;
          end
        end
        ST_PRE: begin
          if (t_done) begin
            state <= ST_IDLE;
          end
        end
        ST_CBR_COL: begin
          if (t_done) begin
            strobes.row_strobe_n <= 1'b0;
            state                <= ST_CBR_ROW;
          end
        end
        ST_CBR_ROW: begin
          if (t_done) begin
            strobes <= '1;
            if (waking) begin
              wake_count <= wake_count + 1'b1;
              if (wake_count == fpd_pkg::WAKE_LAST) begin
                waking    <= 1'b0;
                init_done <= 1'b1;
              end
            end else if (ref_late) begin
              waking     <= 1'b1;
              wake_count <= 3'h0;
              init_done  <= 1'b0;
            end
            state <= ST_PRE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end
endmodule

// ### sim/fpd_ctrl_assertions.sv
// Purpose: strobe order and timing checks on the controller pins
// Assumes: one clock domain, reset active low
// Notes:   counts are in mclk cycles at 25 ns
`timescale 1ns/1ps
module fpd_ctrl_assertions #(
  parameter int REFRESH_CYCLES = fpd_pkg::REFRESH_INT_CYC
) (
  input wire logic                       mclk,
  input wire logic                       resetn,
  input wire logic                       req_ready,
  input wire logic                       init_done,
  input wire fpd_pkg::fpd_strobe_type    strobes,
  input wire logic [fpd_pkg::ADDR_W-1:0] mux_address_bus,
  input wire logic [1:0]                 data_pins_oe
);
  localparam int GAP_MAX = 2 * REFRESH_CYCLES + 32;
  wire        ras_n = strobes.row_strobe_n;
  wire        lower_col_strobe_n_n = strobes.lower_col_strobe_n;
  wire        upper_col_strobe_n_n = strobes.upper_col_strobe_n;
  wire        cas_n = lower_col_strobe_n_n & upper_col_strobe_n_n;
  logic       ras_q;
  logic [15:0] gap;
  logic [3:0] wakes;
  // cycles since the last row strobe fall, and falls since reset
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ras_q <= 1'b1;
      gap <= 16'h0000;
      wakes <= 4'h0;
    end else begin
      ras_q <= ras_n;
      gap <= (ras_q && !ras_n) ? 16'h0000 : gap + {15'h0000, gap != 16'hFFFF};
      wakes <= wakes + {3'h0, ras_q && !ras_n && wakes != 4'hF};
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  chk_row_active_min: assert property (
    $fell(ras_n) |-> !ras_n [*2]) else $error("row strobe low too briefly");
  chk_row_precharge: assert property (
    $rose(ras_n) |-> ras_n [*2]) else $error("row precharge too short");
  chk_refresh_setup: assert property (
    $fell(ras_n) && !cas_n |-> $past(!cas_n)) else $error("column strobe not set up");
  chk_col_addr_set: assert property (
    $fell(cas_n) && !ras_n |-> $stable(mux_address_bus)) else $error("column address moved");
  chk_write_data_on: assert property (
    !ras_n && !strobes.write_en_n |-> (data_pins_oe[0] || lower_col_strobe_n_n) && (data_pins_oe[1] || upper_col_strobe_n_n))
    else $error("write lane not driven");
  chk_read_released: assert property (
    !strobes.out_en_n && strobes.write_en_n |-> data_pins_oe == 2'b00)
    else $error("data driven during read");
  chk_ready_after_wake: assert property (
    req_ready |-> init_done) else $error("request taken before wake-up");
  chk_wake_count: assert property (
    $rose(init_done) |-> wakes >= 4'h8) else $error("too few wake-up cycles");
  chk_refresh_gap: assert property (
    init_done |-> gap <= GAP_MAX) else $error("refresh interval exceeded");
endmodule
bind fpd_ctrl fpd_ctrl_assertions #(.REFRESH_CYCLES(REFRESH_CYCLES)) u_chk (
  .mclk(mclk), .resetn(resetn), .req_ready(req_ready), .init_done(init_done),
  .strobes(strobes), .mux_address_bus(mux_address_bus), .data_pins_oe(data_pins_oe));

// ### sim/fpd_mem_model.sv
// Purpose: behavioural 1M x 16 fast-page dynamic memory on the controller pins
// Assumes: strobes active low, lane enables high while the controller drives
// Notes:   released lanes show the inverse of the last word read
`timescale 1ns/1ps
module fpd_mem_model (
  input  wire fpd_pkg::fpd_strobe_type strobes,
  input  wire logic [9:0]              mux_address_bus,
  input  wire logic [15:0]             data_pins_out,
  input  wire logic [1:0]              data_pins_oe,
  output logic [15:0]                  data_pins_in,
  output int                           cbr_count
);
  logic [15:0] mem [bit [19:0]];
  logic [9:0]  row;
  logic [9:0]  col;
  logic [8:0]  rfsh_row = 9'h000;
  logic [15:0] rdq = 16'h0000;
  logic [15:0] w;
  logic        col_before_row_refresh = 1'b0;
  logic        acc_ok = 1'b0;
  wire         lower_col_strobe_n_n = strobes.lower_col_strobe_n;
  wire         upper_col_strobe_n_n = strobes.upper_col_strobe_n;
  wire         cas_n = lower_col_strobe_n_n & upper_col_strobe_n_n;
  wire         rd = !strobes.row_strobe_n && !col_before_row_refresh && strobes.write_en_n
                    && !strobes.out_en_n && acc_ok;
  initial cbr_count = 0;
  // store lanes whose strobe is low; an undriven lane stores unknown
  task automatic store();
    if (!strobes.row_strobe_n && !col_before_row_refresh && !cas_n && !strobes.write_en_n) begin
      w = mem.exists({row, col}) ? mem[{row, col}] : 16'h0000;
      if (!lower_col_strobe_n_n) w[7:0] = data_pins_oe[0] ? data_pins_out[7:0] : 8'hXX;
      if (!upper_col_strobe_n_n) w[15:8] = data_pins_oe[1] ? data_pins_out[15:8] : 8'hXX;
      mem[{row, col}] = w;
    end
  endtask
  // row strobe fall opens a row or refreshes from the internal counter
  always @(negedge strobes.row_strobe_n) begin
    col_before_row_refresh = !cas_n;
    if (col_before_row_refresh) begin
      cbr_count++;
      rfsh_row = rfsh_row + 9'h001;
    end else
      row = mux_address_bus;
  end
  // first column strobe fall latches the column and starts access time
  always @(negedge cas_n) begin
    acc_ok = 1'b0;
    if (!strobes.row_strobe_n && !col_before_row_refresh) begin
      col = mux_address_bus;
      store();
      rdq = mem.exists({row, col}) ? mem[{row, col}] : 16'h0000;
    end
    #25 acc_ok = 1'b1;
  end
  always @(posedge cas_n) acc_ok = 1'b0;
  // late write enable; delayed so the column latch lands first
  always @(negedge strobes.write_en_n) #1 store();
  // each lane drives only with its own strobe low; a collision reads unknown
  always @* begin
    for (int l = 0; l < 2; l++) begin
      if (data_pins_oe[l] && rd && !(l ? upper_col_strobe_n_n : lower_col_strobe_n_n)) data_pins_in[l*8 +: 8] = 8'hXX;
      else if (data_pins_oe[l]) data_pins_in[l*8 +: 8] = data_pins_out[l*8 +: 8];
      else if (rd && !(l ? upper_col_strobe_n_n : lower_col_strobe_n_n)) data_pins_in[l*8 +: 8] = rdq[l*8 +: 8];
      else data_pins_in[l*8 +: 8] = ~rdq[l*8 +: 8];
    end
  end
endmodule

// ### sim/async_fast_page_dram_interface_tb.sv
// Purpose: self-checking bench for the fast-page dynamic memory controller
// Assumes: power-up wait set to zero, refresh interval shortened
// Notes:   expected contents are kept here from the requests sent
`timescale 1ns/1ps
`define CHECK(got, want) begin n_tests++; if ((got) !== (want)) begin err_count++; \
  $display("unexpected at %0t: got %0h want %0h", $time, (got), (want)); end end
module async_fast_page_dram_interface_tb;
  localparam int REFRESH = 50;
  logic                    mclk = 1'b0;
  logic                    resetn = 1'b0;
  logic                    ce = 1'b1;
  logic                    req_valid = 1'b0;
  fpd_pkg::fpd_req_type    req = '0;
  logic                    req_ready;
  logic                    rsp_valid;
  logic                    init_done;
  fpd_pkg::fpd_strobe_type strobes;
  logic [9:0]              mux_address_bus;
  logic [15:0]             rsp_data;
  logic [15:0]             data_pins_out;
  logic [1:0]              data_pins_oe;
  logic [15:0]             data_pins_in;
  logic [15:0]             q;
  logic [15:0]             exp_mem [bit [19:0]];
  logic [19:0]             addrs [5] = '{20'h00C05, 20'h00C06, 20'hAF005, 20'hFFFFF, 20'h00000};
  int                      cbr_count;
  int                      err_count = 0;
  int                      n_tests = 0;
  int                      cycles = 0;
  fpd_ctrl #(.POWER_UP_CYCLES(0), .REFRESH_CYCLES(REFRESH)) dut (
    .mclk(mclk), .resetn(resetn), .ce(ce), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .init_done(init_done),
    .strobes(strobes), .mux_address_bus(mux_address_bus), .data_pins_out(data_pins_out),
    .data_pins_oe(data_pins_oe), .data_pins_in(data_pins_in));
  fpd_mem_model u_mem (
    .strobes(strobes), .mux_address_bus(mux_address_bus), .data_pins_out(data_pins_out),
    .data_pins_oe(data_pins_oe), .data_pins_in(data_pins_in), .cbr_count(cbr_count));
  always #12.5 mclk = ~mclk;
  // cut a hung run short
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      $display("unexpected at %0t: run too long", $time);
      results();
    end
  end
  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // one request held until taken, then wait for its answer
  task automatic access(input logic wr, input logic [19:0] a, input logic [15:0] d,
                        input logic [1:0] ln, output logic [15:0] r);
    int n;
    n = 0;
    req_valid <= 1'b1;
    req <= '{addr: a, wdata: d, lanes: ln, write: wr};
    do begin @(posedge mclk); n++; end while (req_ready !== 1'b1 && n < 500);
    req_valid <= 1'b0;
    do begin @(posedge mclk); n++; end while (rsp_valid !== 1'b1 && n < 1000);
    r = rsp_data;
    if (n >= 1000) begin err_count++; $display("unexpected at %0t: no answer", $time); end
  endtask
  task automatic wr(input logic [19:0] a, input logic [15:0] d, input logic [1:0] ln);
    logic [15:0] e;
    e = exp_mem.exists(a) ? exp_mem[a] : 16'h0000;
    if (ln[0]) e[7:0] = d[7:0];
    if (ln[1]) e[15:8] = d[15:8];
    exp_mem[a] = e;
    access(1'b1, a, d, ln, q);
  endtask
  task automatic t_init();
    int n;
    n = 0;
    while (init_done !== 1'b1 && n < 2000) begin @(posedge mclk); n++; end
    `CHECK(init_done, 1'b1)
    `CHECK(cbr_count >= 8, 1'b1)
  endtask
  // page hit, row miss and corner addresses
  task automatic t_words();
    for (int i = 0; i < 5; i++) wr(addrs[i], 16'hA55A ^ (16'h1111 * 16'(i)), 2'b11);
    for (int i = 0; i < 5; i++) begin
      access(1'b0, addrs[i], 16'h0000, 2'b11, q);
      `CHECK(q, exp_mem[addrs[i]])
    end
  endtask
  task automatic t_bytes();
    wr(addrs[0], 16'h12FF, 2'b10);
    wr(addrs[0], 16'hEE34, 2'b01);
    access(1'b0, addrs[0], 16'h0000, 2'b01, q);
    `CHECK(q[7:0], 8'h34)
    access(1'b0, addrs[0], 16'h0000, 2'b10, q);
    `CHECK(q[15:8], 8'h12)
    access(1'b0, addrs[0], 16'h0000, 2'b11, q);
    `CHECK(q, 16'h1234)
  endtask
  task automatic t_refresh();
    int c;
    c = cbr_count;
    repeat (3 * REFRESH) @(posedge mclk);
    `CHECK(cbr_count >= c + 2, 1'b1)
    access(1'b0, addrs[3], 16'h0000, 2'b11, q);
    `CHECK(q, exp_mem[addrs[3]])
  endtask
  // clock enable low freezes the strobes and the refresh timer
  task automatic t_hold();
    fpd_pkg::fpd_strobe_type s;
    int c;
    ce <= 1'b0;
    @(posedge mclk);
    s = strobes;
    c = cbr_count;
    repeat (40) @(posedge mclk);
    `CHECK(strobes, s)
    `CHECK(cbr_count, c)
    ce <= 1'b1;
  endtask
  initial begin
    repeat (16) @(posedge mclk);
    resetn <= 1'b1;
    t_init();
    t_words();
    t_bytes();
    t_hold();
    t_refresh();
    results();
  end
endmodule
